// file: rtl/adc_ctrl_pkg.sv
/*
  Shared constants for the converter sequencing control: register map,
  field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
*/
`default_nettype none

package adc_ctrl_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int RESULT_W = 10;
  localparam int RESULT_HIGH_W = 8;
  localparam int CHAN_W = 2;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int EVT_W = 2;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CHAN = 8'h04;
  localparam logic [ADR_W-1:0] OFS_RESULT = 8'h08;
  localparam logic [ADR_W-1:0] OFS_RESULT_HIGH = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADR_W-1:0] OFS_MASK = 8'h14;

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_START_POS = 7;
  localparam int MODE_ENABLE_POS = 0;
  localparam int EVT_DONE_POS = 0;
  localparam int EVT_SUSPECT_POS = 1;
  localparam int STAT_BUSY_POS = 4;
  localparam int STAT_SETTLED_POS = 5;
  localparam int SEL_LOW_LANE = 0;

  //////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [CHAN_W-1:0] CHAN_RESET = 2'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
  localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam int SAMPLE_CYCLES = 4;
  localparam int SAMPLE_CNT_W = $clog2(SAMPLE_CYCLES + 1);
  localparam int BIT_CNT_W = $clog2(RESULT_W + 1);

endpackage : adc_ctrl_pkg

`default_nettype wire

// file: rtl/comparator_settle_timer.sv
/*
  Counts the comparator settling time after the enable bit rises.
  Assumes the enable level comes from a register in the same clock domain.
*/
`default_nettype none

module comparator_settle_timer
  import adc_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic enable_in,
  output logic settled_out
);

  logic [SETTLE_CNT_W-1:0] count;
  logic [SETTLE_CNT_W-1:0] next_count;

  //////////////////////////////////////////////////////////////////////////
  // Restart from zero whenever the comparator is off
  always_comb begin
    next_count = count;
    if (!enable_in) begin
      next_count = '0;
    end else if (count != SETTLE_CNT_W'(SETTLE_CYCLES)) begin
      next_count = count + SETTLE_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (ce_in) begin
      count <= next_count;
    end
  end

  assign settled_out = (count == SETTLE_CNT_W'(SETTLE_CYCLES)); // Saturates, stays high

endmodule : comparator_settle_timer

`default_nettype wire

// file: rtl/sar_engine.sv
/*
  Successive-approximation sequencer: samples the chosen input, then
  resolves one bit per cycle against the external comparator.
  Assumes comp_in settles within the cycle on the trial code now on
  dac_code_out (high when the input is at or above the code).
*/
`default_nettype none

module sar_engine
  import adc_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic comp_in,
  output logic busy_out,
  output logic sample_out,
  output logic done_out,
  output logic [RESULT_W-1:0] dac_code_out,
  output logic [RESULT_W-1:0] result_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sar_state_t;

  sar_state_t state;
  sar_state_t next_state;
  logic [SAMPLE_CNT_W-1:0] samp_cnt;
  logic [SAMPLE_CNT_W-1:0] next_samp_cnt;
  logic [BIT_CNT_W-1:0] bit_idx;
  logic [BIT_CNT_W-1:0] next_bit_idx;
  logic [RESULT_W-1:0] code;
  logic [RESULT_W-1:0] next_code;
  logic next_done;
  logic [RESULT_W-1:0] next_result;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer; abort drops a conversion without a completion pulse
  always_comb begin
    next_state = state;
    next_samp_cnt = samp_cnt;
    next_bit_idx = bit_idx;
    next_code = code;
    next_done = 1'b0;
    next_result = result_out;
    case (state)
      ST_IDLE: begin
        if (start_in && !abort_in) begin
          next_state = ST_SAMPLE;
          next_samp_cnt = '0;
        end
      end
      ST_SAMPLE: begin
        next_samp_cnt = samp_cnt + SAMPLE_CNT_W'(1);
        if (next_samp_cnt == SAMPLE_CNT_W'(SAMPLE_CYCLES)) begin
          next_state = ST_CONVERT;
          next_bit_idx = BIT_CNT_W'(RESULT_W - 1);
          next_code = '0;
          next_code[RESULT_W-1] = 1'b1; // First trial: mid scale
        end
      end
      ST_CONVERT: begin
        if (!comp_in) begin
          next_code[bit_idx] = 1'b0; // Trial too high, drop it
        end
        if (bit_idx == '0) begin
          next_state = ST_IDLE;
          next_done = 1'b1;
          next_result = next_code;
        end else begin
          next_bit_idx = bit_idx - BIT_CNT_W'(1);
          next_code[next_bit_idx] = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (abort_in) begin
      next_state = ST_IDLE;
      next_done = 1'b0;
      next_result = result_out;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      samp_cnt <= '0;
      bit_idx <= '0;
      code <= RESULT_RESET;
      done_out <= 1'b0;
      result_out <= RESULT_RESET;
    end else if (ce_in) begin
      state <= next_state;
      samp_cnt <= next_samp_cnt;
      bit_idx <= next_bit_idx;
      code <= next_code;
      done_out <= next_done;
      result_out <= next_result;
    end
  end

  assign busy_out = (state != ST_IDLE);
  assign sample_out = (state == ST_SAMPLE);
  assign dac_code_out = code;

endmodule : sar_engine

`default_nettype wire

// file: rtl/adc_sequencing_control.sv
/*
  Digital control around a successive-approximation converter: mode and
  channel registers, result register, completion flag and interrupt,
  reached over a classic Wishbone slave.
  Assumes a synchronous comparator input, one 100 MHz clock and a
  synchronous active-high reset.

*/
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none

module adc_sequencing_control
  import adc_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [SEL_W-1:0] wb_sel_in,
  input wire logic [DAT_W-1:0] wb_dat_in,
  output logic [DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic comp_in,
  output logic comparator_power_out,
  output logic sample_out,
  output logic [CHAN_W-1:0] analog_input_select_out,
  output logic [RESULT_W-1:0] dac_code_out,
  output logic conv_end_irq_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic conv_start_bit;
  logic next_conv_start_bit;
  logic comparator_enable_bit;
  logic next_comparator_enable_bit;
  logic [CHAN_W-1:0] channel_select_reg;
  logic [CHAN_W-1:0] next_channel_select_reg;
  logic [RESULT_W-1:0] conv_result_reg;
  logic [RESULT_W-1:0] next_conv_result_reg;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] next_mask;
  logic pend_valid;
  logic next_pend_valid;
  logic [RESULT_W-1:0] pend_result;
  logic [RESULT_W-1:0] next_pend_result;
  logic first_pending;
  logic next_first_pending;
  logic first_suspect;
  logic next_first_suspect;
  logic next_conv_end_irq;
  logic next_ack;
  logic [DAT_W-1:0] next_dat;

  logic req;
  logic wr;
  logic rd_capture;
  logic wr_low;
  logic wr_mode;
  logic wr_cfg;
  logic rd_res;
  logic eng_busy;
  logic eng_done;
  logic eng_start;
  logic [RESULT_W-1:0] eng_result;
  logic settled;
  logic commit;
  logic [RESULT_W-1:0] commit_value;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: data captured on the request cycle, writes act on the ack edge
  assign req = wb_cyc_in && wb_stb_in;
  assign rd_capture = req && !wb_ack_out && !wb_we_in;
  assign wr = req && wb_ack_out && wb_we_in;
  assign wr_low = wr && wb_sel_in[SEL_LOW_LANE];
  assign wr_mode = wr_low && (wb_adr_in == OFS_MODE);
  assign wr_cfg = wr_low && ((wb_adr_in == OFS_MODE) || (wb_adr_in == OFS_CHAN));
  assign rd_res = rd_capture && ((wb_adr_in == OFS_RESULT) || (wb_adr_in == OFS_RESULT_HIGH));

  ////////////////////////////////////////////////////////////////////////////
  // Comparator settling and the conversion engine
  comparator_settle_timer u_settle (
    .sys_clk_in (sys_clk_in),
    .rst_in (rst_in),
    .ce_in (ce_in),
    .enable_in (comparator_enable_bit),
    .settled_out (settled)
  );

  // Restart right after each completion while start stays set
  assign eng_start = conv_start_bit && !eng_busy && !wr_cfg;

  sar_engine u_sar (
    .sys_clk_in (sys_clk_in),
    .rst_in (rst_in),
    .ce_in (ce_in),
    .start_in (eng_start),
    .abort_in (wr_cfg),
    .comp_in (comp_in),
    .busy_out (eng_busy),
    .sample_out (sample_out),
    .done_out (eng_done),
    .dac_code_out (dac_code_out),
    .result_out (eng_result)
  );

  // Idle with start clear powers the comparator only while the enable bit is set
  assign comparator_power_out = comparator_enable_bit || conv_start_bit;
  assign analog_input_select_out = channel_select_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Completion arbitration against register traffic
  always_comb begin
    commit = 1'b0;
    commit_value = eng_result;
    next_pend_valid = 1'b0;
    next_pend_result = pend_result;
    if (pend_valid) begin
      commit = 1'b1; // Deferred result lands one cycle after the read
      commit_value = pend_result;
    end else if (eng_done && !wr_cfg) begin
      if (rd_res) begin
        next_pend_valid = 1'b1;
        next_pend_result = eng_result;
      end else begin
        commit = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pend_valid <= 1'b0;
      pend_result <= RESULT_RESET;
    end else if (ce_in) begin
      pend_valid <= next_pend_valid;
      pend_result <= next_pend_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and first-result tracking
  always_comb begin
    next_conv_start_bit = conv_start_bit;
    next_comparator_enable_bit = comparator_enable_bit;
    next_channel_select_reg = channel_select_reg;
    next_mask = mask;
    next_first_pending = first_pending;
    next_first_suspect = first_suspect;
    next_conv_result_reg = conv_result_reg;
    if (commit) begin
      next_conv_result_reg = commit_value;
      next_first_pending = 1'b0;
    end
    if (wr_mode) begin
      next_conv_start_bit = wb_dat_in[MODE_START_POS];
      next_comparator_enable_bit = wb_dat_in[MODE_ENABLE_POS];
      // A fresh start judges its first result by the comparator's state now
      if (wb_dat_in[MODE_START_POS] && !conv_start_bit) begin
        next_first_pending = 1'b1;
        next_first_suspect = !settled || !comparator_enable_bit;
      end
    end
    // Old result is left as is; software must not trust it after this write
    if (wr_low && (wb_adr_in == OFS_CHAN)) begin
      next_channel_select_reg = wb_dat_in[CHAN_W-1:0];
    end
    if (wr_low && (wb_adr_in == OFS_MASK)) begin
      next_mask = wb_dat_in[EVT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      conv_start_bit <= 1'b0;
      comparator_enable_bit <= 1'b0;
      channel_select_reg <= CHAN_RESET;
      mask <= EVT_RESET;
      first_pending <= 1'b0;
      first_suspect <= 1'b0;
      conv_result_reg <= RESULT_RESET;
    end else if (ce_in) begin
      conv_start_bit <= next_conv_start_bit;
      comparator_enable_bit <= next_comparator_enable_bit;
      channel_select_reg <= next_channel_select_reg;
      mask <= next_mask;
      first_pending <= next_first_pending;
      first_suspect <= next_first_suspect;
      conv_result_reg <= next_conv_result_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events: set wins over a write-one clear in the same cycle
  always_comb begin
    evt_set = EVT_RESET;
    evt_set[EVT_DONE_POS] = commit;
    evt_set[EVT_SUSPECT_POS] = commit && first_pending && first_suspect;
    evt_clr = EVT_RESET;
    // Only the status register clears; a channel write leaves the flag alone
    if (wr_low && (wb_adr_in == OFS_STATUS)) begin
      evt_clr = wb_dat_in[EVT_W-1:0];
    end
    next_status = (status & ~evt_clr) | evt_set;
    next_conv_end_irq = commit;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      status <= EVT_RESET;
      conv_end_irq_out <= 1'b0;
    end else if (ce_in) begin
      status <= next_status;
      conv_end_irq_out <= next_conv_end_irq;
    end
  end

  assign irq_out = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and ack; unmapped addresses ack with zero data
  always_comb begin
    next_ack = req && !wb_ack_out;
    next_dat = DAT_ZERO;
    if (rd_capture) begin
      case (wb_adr_in)
        OFS_MODE: begin
          next_dat[MODE_START_POS] = conv_start_bit;
          next_dat[MODE_ENABLE_POS] = comparator_enable_bit;
        end
        OFS_CHAN: begin
          next_dat[CHAN_W-1:0] = channel_select_reg;
        end
        OFS_RESULT: begin
          next_dat[RESULT_W-1:0] = conv_result_reg;
        end
        OFS_RESULT_HIGH: begin
          next_dat[RESULT_HIGH_W-1:0] = conv_result_reg[RESULT_W-1 -: RESULT_HIGH_W];
        end
        OFS_STATUS: begin
          next_dat[EVT_W-1:0] = status;
          next_dat[STAT_BUSY_POS] = eng_busy;
          next_dat[STAT_SETTLED_POS] = settled;
        end
        OFS_MASK: begin
          next_dat[EVT_W-1:0] = mask;
        end
        default: begin
          next_dat = DAT_ZERO;
        end
      endcase
    end else if (wb_ack_out) begin
      next_dat = DAT_ZERO;
    end else begin
      next_dat = wb_dat_out;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= DAT_ZERO;
    end else if (ce_in) begin
      wb_ack_out <= next_ack;
      wb_dat_out <= next_dat;
    end
  end

endmodule : adc_sequencing_control

`default_nettype wire

// file: sim/adc_seq_checker_sva.sv
/*
  Port checker for adc_sequencing_control: bus handshake, conversion
  timing, completion pulse and interrupt causes.
  Assumes ce_in is held high and one clock domain.
*/
`default_nettype none

module adc_seq_checker
  import adc_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [SEL_W-1:0] wb_sel_in,
  input wire logic [DAT_W-1:0] wb_dat_in,
  input wire logic [DAT_W-1:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic comp_in,
  input wire logic comparator_power_out,
  input wire logic sample_out,
  input wire logic [CHAN_W-1:0] analog_input_select_out,
  input wire logic [RESULT_W-1:0] dac_code_out,
  input wire logic conv_end_irq_out,
  input wire logic irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one-cycle answer, data only beside ack
  ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == DAT_ZERO)
    else $error("read data driven without ack");

  ////////////////////////////////////////////////////////////////////////////
  // Conversion engine; aborts come only from a write ack
  sample_len_a: assert property ($fell(sample_out) && !$past(wb_ack_out)
    |-> $past(sample_out, 4) && !$past(sample_out, 5))
    else $error("sampling phase not four cycles");
  power_sample_a: assert property (sample_out |-> comparator_power_out)
    else $error("sampling with comparator unpowered");
  restart_next_a: assert property (
    conv_end_irq_out && !wb_stb_in |-> ##[0:1] sample_out)
    else $error("no back-to-back restart after completion");
  irq_pulse_a: assert property (conv_end_irq_out |=> !conv_end_irq_out)
    else $error("completion pulse longer than one cycle");
  write_wins_a: assert property (conv_end_irq_out |-> !$past(wb_ack_out && wb_we_in
    && wb_sel_in[SEL_LOW_LANE] && (wb_adr_in == OFS_MODE || wb_adr_in == OFS_CHAN)))
    else $error("completion committed on a mode or channel write");
  chan_by_write_a: assert property ($changed(analog_input_select_out)
    |-> $past(wb_ack_out && wb_we_in && wb_adr_in == OFS_CHAN))
    else $error("channel select moved without a channel write");
  irq_cause_a: assert property ($rose(irq_out) |-> conv_end_irq_out
    || $past(wb_ack_out && wb_we_in))
    else $error("interrupt rose without completion or write");

  // Main scenarios reached
  read_cv: cover property (wb_ack_out && !wb_we_in);
  conv_cv: cover property (conv_end_irq_out);
  irq_cv: cover property ($rose(irq_out));
  sample_cv: cover property ($rose(sample_out));
endmodule // adc_seq_checker

bind adc_sequencing_control adc_seq_checker chk (.sys_clk_in, .rst_in, .ce_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
  .comp_in, .comparator_power_out, .sample_out, .analog_input_select_out, .dac_code_out,
  .conv_end_irq_out, .irq_out);

`default_nettype wire

// file: sim/adc_sequencing_control_test.sv
/*
  Self-checking bench for adc_sequencing_control.
  Assumes a comparator modelled from a fixed analog level; ce_in stays high.
*/
`default_nettype none

module adc_sequencing_control_test
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [SEL_W-1:0] sel = 4'h0;
  logic [DAT_W-1:0] dat = 32'h0000_0000;
  logic comp_in;
  logic [RESULT_W-1:0] analog = 10'h2a5;
  logic [DAT_W-1:0] wb_dat_out;
  logic [DAT_W-1:0] rd;
  logic wb_ack_out;
  logic comparator_power_out;
  logic sample_out;
  logic [CHAN_W-1:0] analog_input_select_out;
  logic [RESULT_W-1:0] dac_code_out;
  logic conv_end_irq_out;
  logic irq_out;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  adc_sequencing_control dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .comp_in(comp_in),
    .comparator_power_out(comparator_power_out), .sample_out(sample_out),
    .analog_input_select_out(analog_input_select_out), .dac_code_out(dac_code_out),
    .conv_end_irq_out(conv_end_irq_out), .irq_out(irq_out));

  initial forever #5 sys_clk_in = ~sys_clk_in;

  // Comparator settles within the cycle on the trial code now shown
  assign comp_in = (analog >= dac_code_out);

  // Watchdog: whole run is well under two thousand cycles
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("errors %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task check(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; request held until ack is sampled, a hang is the watchdog's
  task wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    @(posedge sys_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge sys_clk_in);
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wait_done;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (conv_end_irq_out !== 1'b1 && n < 100);
    check(32'(conv_end_irq_out), 32'h0000_0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped and read-only places
  task t_reset;
    logic [ADR_W-1:0] offs [7];
    offs = '{OFS_MODE, OFS_CHAN, OFS_RESULT, OFS_RESULT_HIGH, OFS_STATUS, OFS_MASK, 8'h20};
    wb(1'b1, 8'h20, 32'hffff_ffff);
    wb(1'b1, OFS_RESULT, 32'h0000_03ff);
    foreach (offs[i]) begin
      wb(1'b0, offs[i], DAT_ZERO);
      check(rd, DAT_ZERO);
    end
    check(32'(irq_out), DAT_ZERO);
    check(32'(comparator_power_out), DAT_ZERO);
  endtask

  // Start with comparator off: suspect flag, result, flag kept over channel write
  task t_cold;
    wb(1'b1, OFS_MASK, 32'h0000_0001);
    wb(1'b1, OFS_MODE, 32'h0000_0080);
    wait_done();
    check(32'(irq_out), 32'h0000_0001);
    wb(1'b0, OFS_RESULT, DAT_ZERO);
    check(rd, 32'(analog));
    wb(1'b0, OFS_RESULT_HIGH, DAT_ZERO);
    check(rd, 32'(analog[9:2]));
    wb(1'b1, OFS_MODE, DAT_ZERO);
    wb(1'b1, OFS_CHAN, 32'h0000_0002);
    wb(1'b0, OFS_STATUS, DAT_ZERO);
    check(rd & 32'h0000_0003, 32'h0000_0003);
    check(32'(analog_input_select_out), 32'h0000_0002);
    wb(1'b1, OFS_STATUS, 32'h0000_0003);
    wb(1'b0, OFS_STATUS, DAT_ZERO);
    check(rd & 32'h0000_0003, DAT_ZERO);
    check(32'(irq_out), DAT_ZERO);
  endtask

  // Settled start: waiting state, repeated conversions, no suspect flag, masking
  task t_warm;
    int pulses;
    analog <= 10'h13c;
    wb(1'b1, OFS_MODE, 32'h0000_0001);
    repeat (110) @(posedge sys_clk_in);
    check(32'(comparator_power_out), 32'h0000_0001);
    check(32'(sample_out), DAT_ZERO);
    wb(1'b1, OFS_STATUS, 32'h0000_0003);
    wb(1'b1, OFS_MODE, 32'h0000_0081);
    wait_done();
    pulses = 0;
    repeat (64) begin
      @(posedge sys_clk_in);
      if (conv_end_irq_out === 1'b1) pulses++;
    end
    check(32'(pulses >= 3), 32'h0000_0001);
    wb(1'b0, OFS_RESULT, DAT_ZERO);
    check(rd, 32'h0000_013c);
    // Result read captured in the completion cycle: old value, commit one cycle late
    wait_done();
    analog <= 10'h0c3;
    repeat (12) @(posedge sys_clk_in);
    wb(1'b0, OFS_RESULT, DAT_ZERO);
    check(rd, 32'h0000_013c);
    check(32'(conv_end_irq_out), DAT_ZERO);
    @(posedge sys_clk_in);
    check(32'(conv_end_irq_out), 32'h0000_0001);
    wb(1'b0, OFS_RESULT, DAT_ZERO);
    check(rd, 32'h0000_00c3);
    // Mode write acked on the completion edge: no pulse, result kept
    wait_done();
    analog <= 10'h155;
    repeat (11) @(posedge sys_clk_in);
    wb(1'b1, OFS_MODE, 32'h0000_0081);
    @(posedge sys_clk_in);
    check(32'(conv_end_irq_out), DAT_ZERO);
    wb(1'b0, OFS_RESULT, DAT_ZERO);
    check(rd, 32'h0000_00c3);
    wb(1'b1, OFS_MODE, 32'h0000_0001);
    wb(1'b0, OFS_STATUS, DAT_ZERO);
    check(rd & 32'h0000_0023, 32'h0000_0021);
    check(32'(irq_out), 32'h0000_0001);
    wb(1'b1, OFS_MASK, DAT_ZERO);
    wb(1'b0, OFS_MASK, DAT_ZERO);
    check(32'(irq_out), DAT_ZERO);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_cold();
    t_warm();
    complete_run();
  end
endmodule // adc_sequencing_control_test

`default_nettype wire
